// File: wdtc_edge_det.sv
// three-stage synchroniser with self-clearing rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module wdtc_edge_det (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic lineIn,
   output logic risePulse
);
   logic s1_q, s2_q, s3_q, level_q;
   wire agree = (s2_q == s3_q);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
         risePulse <= 1'b0;
      end else begin
         s1_q <= lineIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) level_q <= s3_q;
         // one pulse per rise however long the line stays high, see RULE4
         risePulse <= agree && s3_q && !level_q;
      end
   end
endmodule
`default_nettype wire

// File: wdtc_kbc_model.sv
// keyboard controller output line model
`timescale 1ns/1ps
`default_nettype none
module wdtc_kbc_model #(
   parameter int HOLD = 300
) (
   input wire logic mclk,
   input wire logic fire,
   input wire logic stay,
   output logic kbcLine
);
   int cnt = 0;
   always_ff @(posedge mclk) begin
      if (fire) cnt <= HOLD;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign kbcLine = stay | (cnt > 0);
endmodule
`default_nettype wire

// File: wdtc_pkg.sv
// package of constants and types for the watchdog timeout control block
// Overview of operation
// RULE1 - control bit 0 reports timeout status, writable
// RULE2 - writing bit 2 forces timeout, self-clears
// RULE3 - bit 3 enables keyboard line edge trigger
// RULE4 - edge detector ORed with software force
// RULE5 - power-on clears all; bus reset keeps status
// RULE6 - software writes zeros to bits 7:4
// RULE7 - eight-bit length, zero disables timeout
// RULE8 - units bit 7: minutes default, seconds
// RULE9 - enabled joystick, keyboard, mouse restarts reload
// RULE10 - four-bit irq map, 0000 off, 0010 invalid
// RULE11 - timeout sets status, irq until cleared
package wdtc_pkg;
   localparam logic [7:0] WDTC_UNITS_OFS = 8'h52;
   localparam logic [7:0] WDTC_VALUE_OFS = 8'h53;
   localparam logic [7:0] WDTC_CFG_OFS = 8'h54;
   localparam logic [7:0] WDTC_CTRL_OFS = 8'h55;
   localparam logic [7:0] WDTC_ISTAT_OFS = 8'h60;
   localparam logic [7:0] WDTC_IMASK_OFS = 8'h61;
   localparam logic [7:0] WDTC_RESET_VAL = 8'h00;
   localparam int WDTC_STAT_BIT = 0;
   localparam int WDTC_FORCE_BIT = 2;
   localparam int WDTC_KBEN_BIT = 3;
   localparam int WDTC_UNIT_BIT = 7;
   localparam int WDTC_JOY_BIT = 0;
   localparam int WDTC_KBD_BIT = 1;
   localparam int WDTC_MOU_BIT = 2;
   localparam logic [3:0] WDTC_IRQ_OFF = 4'h0;
   localparam logic [3:0] WDTC_IRQ_BAD = 4'h2;
   localparam int WDTC_CLK_MHZ = 250;
   localparam int WDTC_SECOND_NS = 1000000000;
   localparam int WDTC_CLK_NS = 1000 / WDTC_CLK_MHZ;
   localparam int WDTC_SEC_CYC = WDTC_SECOND_NS / WDTC_CLK_NS;
   localparam int WDTC_MIN_SEC = 60;
   typedef struct packed {
      logic joy;
      logic kbd;
      logic mouse;
   } wdtc_restart_s;
endpackage

// File: wdtc_tb.sv
// self-checking bench for the watchdog timeout control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wdtc_pkg::*;
   logic mclk = 0, rst_n = 0, pciRst_n = 0, hsel = 0, hwrite = 0;
   logic fire = 0, stay = 0, kbcLine, hreadyout, hresp, irqOut;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [15:0] irqLines;
   wdtc_restart_s restartEv = '0;
   int err_total = 0, checks = 0;
   always #2 mclk = ~mclk;
   wdtc_kbc_model kbc_u (.mclk(mclk), .fire(fire), .stay(stay),
      .kbcLine(kbcLine));
   wdtc_top #(.SEC_CYCLES(10), .MIN_SECS(2)) dut_u (.mclk(mclk),
      .rst_n(rst_n), .pciRst_n(pciRst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .kbc_trigger_line(kbcLine), .restartEv(restartEv),
      .irqLines(irqLines), .irqOut(irqOut));
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic waitRdy();
      int i;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         err_total++;
         conclude();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx,
         input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      waitRdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      rd = hrdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic clr();
      bus(1, WDTC_VALUE_OFS, 32'h0);
      bus(1, WDTC_CTRL_OFS, 32'h0);
      bus(1, WDTC_ISTAT_OFS, 32'h3);
   endtask
   task automatic expectTo(input int lo, input int hi);
      int n;
      n = 0;
      while (irqOut !== 1'b1 && n <= hi) begin
         @(posedge mclk);
         n++;
      end
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask
   task automatic tReset();
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      chk(32'(hresp), 32'h0);
      bus(1, 8'h7f, 32'h0000_00ff);
      bus(0, 8'h7f, 32'h0);
      chk(rd, 32'h0);
      $display("reset done");
   endtask
   task automatic tForce();
      bus(1, WDTC_IMASK_OFS, 32'h2);
      bus(1, WDTC_CFG_OFS, 32'h50);
      bus(1, WDTC_CTRL_OFS, 32'h4);
      idle(3);
      chk(32'(irqOut), 32'h1);
      chk(32'(irqLines), 32'h0020);
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h1);
      bus(0, WDTC_ISTAT_OFS, 32'h0);
      chk(rd, 32'h2);
      bus(1, WDTC_CFG_OFS, 32'h20);
      bus(1, WDTC_IMASK_OFS, 32'h0);
      idle(3);
      chk(32'(irqLines), 32'h0);
      chk(32'(irqOut), 32'h0);
      clr();
      $display("force done");
   endtask
   task automatic tKbc();
      stay <= 1'b1;
      idle(10);
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      stay <= 1'b0;
      bus(1, WDTC_CTRL_OFS, 32'h8);
      stay <= 1'b1;
      idle(10);
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h9);
      bus(1, WDTC_CTRL_OFS, 32'h8);
      idle(10);
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h8);
      stay <= 1'b0;
      idle(10);
      fire <= 1'b1;
      idle(1);
      fire <= 1'b0;
      idle(10);
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h9);
      $display("kbc done");
   endtask
   task automatic tPci();
      bus(1, WDTC_CFG_OFS, 32'h31);
      pciRst_n <= 1'b0;
      idle(3);
      pciRst_n <= 1'b1;
      idle(1);
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h1);
      bus(0, WDTC_CFG_OFS, 32'h0);
      chk(rd, 32'h0);
      clr();
      $display("pci done");
   endtask
   task automatic tCount();
      bus(1, WDTC_IMASK_OFS, 32'h1);
      bus(1, WDTC_UNITS_OFS, 32'h80);
      bus(1, WDTC_VALUE_OFS, 32'h2);
      expectTo(16, 28);
      clr();
      bus(1, WDTC_UNITS_OFS, 32'h0);
      bus(1, WDTC_VALUE_OFS, 32'h2);
      expectTo(36, 48);
      clr();
      idle(100);
      chk(32'(irqOut), 32'h0);
      bus(0, WDTC_CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      $display("count done");
   endtask
   task automatic tRestart();
      for (int i = 0; i < 3; i++) begin
         bus(1, WDTC_CFG_OFS, 32'(1 << i));
         bus(1, WDTC_UNITS_OFS, 32'h80);
         bus(1, WDTC_VALUE_OFS, 32'h2);
         repeat (5) begin
            idle(11);
            restartEv <= wdtc_restart_s'(3'h4 >> i);
            idle(1);
            restartEv <= '0;
         end
         chk(32'(irqOut), 32'h0);
         expectTo(16, 28);
         clr();
      end
      $display("restart done");
   endtask
   initial begin
      idle(12);
      rst_n <= 1'b1;
      pciRst_n <= 1'b1;
      idle(1);
      tReset();
      tForce();
      tKbc();
      tPci();
      tCount();
      tRestart();
      conclude();
   end
endmodule
`default_nettype wire

// File: wdtc_top.sv
// watchdog timeout control with ahb-lite register slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wdtc_top
   import wdtc_pkg::*;
#(
   parameter int SEC_CYCLES = WDTC_SEC_CYC,
   parameter int MIN_SECS = WDTC_MIN_SEC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pciRst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic kbc_trigger_line,
   input wire wdtc_restart_s restartEv,
   output logic [15:0] irqLines,
   output logic irqOut
);
   initial begin
      if (SEC_CYCLES < 2 || MIN_SECS < 1)
         $error("wdtc_top: bad timing parameters");
   end
   logic [7:0] units_q, value_q, cfg_q, ctrl_q;
   logic [1:0] istat_q, imask_q;
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   logic [31:0] secCnt_q;
   logic [7:0] minCnt_q, tick_q;
   logic kbRise, hitPrev_q;
   // address phase capture
   wire addrPh = hsel && hready && htrans[1];
   wire [7:0] byteAddr = haddr[9:2] == 8'h00 ? 8'h00 : haddr[9:2];
   wire wrCtrl = wrPend_q && wrAddr_q == WDTC_CTRL_OFS;
   wire wrUnits = wrPend_q && wrAddr_q == WDTC_UNITS_OFS;
   wire wrValue = wrPend_q && wrAddr_q == WDTC_VALUE_OFS;
   wire wrCfg = wrPend_q && wrAddr_q == WDTC_CFG_OFS;
   wire wrIstat = wrPend_q && wrAddr_q == WDTC_ISTAT_OFS;
   wire wrImask = wrPend_q && wrAddr_q == WDTC_IMASK_OFS;
   wire [7:0] rdAddr = haddr[9:2];
   wire [7:0] rdSel;
   assign rdSel = rdAddr == WDTC_CTRL_OFS ? {4'h0, ctrl_q[3], 2'b00,
                                              ctrl_q[0]} :
                  rdAddr == WDTC_UNITS_OFS ? units_q :
                  rdAddr == WDTC_VALUE_OFS ? value_q :
                  rdAddr == WDTC_CFG_OFS ? cfg_q :
                  rdAddr == WDTC_ISTAT_OFS ? {6'h0, istat_q} :
                  rdAddr == WDTC_IMASK_OFS ? {6'h0, imask_q} : 8'h00;
   wdtc_edge_det uEdge (
      .mclk(mclk),
      .rst_n(rst_n),
      .lineIn(kbc_trigger_line),
      .risePulse(kbRise)
   );
   // force strobe ORed with gated keyboard edge, see RULE2 see RULE3 see RULE4
   wire forceEv = (wrCtrl && hwdata[WDTC_FORCE_BIT]) ||
                  (ctrl_q[WDTC_KBEN_BIT] && kbRise);
   // restart sources gated by config except value and units writes, see RULE9
   wire restart = (restartEv.joy && cfg_q[WDTC_JOY_BIT]) ||
                  (restartEv.kbd && cfg_q[WDTC_KBD_BIT]) ||
                  (restartEv.mouse && cfg_q[WDTC_MOU_BIT]) ||
                  wrValue || wrUnits;
   // zero length disables, see RULE7
   wire enabled = value_q != 8'h00;
   wire inSec = units_q[WDTC_UNIT_BIT]; // see RULE8
   wire secDone = secCnt_q == 32'(SEC_CYCLES - 1);
   wire minDone = minCnt_q == 8'(MIN_SECS - 1);
   wire unitDone = secDone && (inSec || minDone);
   wire hit = enabled && unitDone && tick_q == value_q - 8'd1;
   wire expire = hit && !hitPrev_q;
   wire timeoutEv = expire || forceEv; // see RULE11
   wire [3:0] irqMap = cfg_q[7:4];
   wire irqValid = irqMap != WDTC_IRQ_OFF && irqMap != WDTC_IRQ_BAD;
   always_ff @(posedge mclk) begin
      if (!rst_n || !pciRst_n) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wrPend_q <= addrPh && hwrite;
         wrAddr_q <= byteAddr;
         if (addrPh && !hwrite) hrdata <= {24'h00_0000, rdSel};
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_q <= WDTC_RESET_VAL; // see RULE5
      end else if (!pciRst_n) begin
         ctrl_q <= {7'h00, ctrl_q[WDTC_STAT_BIT]}; // see RULE5
      end else begin
         // set wins over software clear, see RULE1 see RULE11
         if (timeoutEv) ctrl_q[WDTC_STAT_BIT] <= 1'b1;
         else if (wrCtrl) ctrl_q[WDTC_STAT_BIT] <= hwdata[WDTC_STAT_BIT];
         // reserved bits held at zero, see RULE6
         if (wrCtrl) ctrl_q[WDTC_KBEN_BIT] <= hwdata[WDTC_KBEN_BIT];
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n || !pciRst_n) begin
         units_q <= WDTC_RESET_VAL;
         value_q <= WDTC_RESET_VAL;
         cfg_q <= WDTC_RESET_VAL;
         imask_q <= 2'b00;
         istat_q <= 2'b00;
      end else begin
         if (wrUnits) units_q <= {hwdata[7], 7'h00};
         if (wrValue) value_q <= hwdata[7:0];
         if (wrCfg) cfg_q <= {hwdata[7:4], 1'b0, hwdata[2:0]};
         if (wrImask) imask_q <= hwdata[1:0];
         istat_q[0] <= expire || (istat_q[0] && !(wrIstat && hwdata[0]));
         istat_q[1] <= forceEv || (istat_q[1] && !(wrIstat && hwdata[1]));
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n || !pciRst_n || restart || !enabled) begin
         secCnt_q <= 32'h0000_0000;
         minCnt_q <= 8'h00;
         tick_q <= 8'h00;
         hitPrev_q <= 1'b0;
      end else if (!ctrl_q[WDTC_STAT_BIT]) begin
         hitPrev_q <= hit;
         secCnt_q <= secDone ? 32'h0000_0000 : secCnt_q + 32'd1;
         if (secDone) minCnt_q <= minDone ? 8'h00 : minCnt_q + 8'd1;
         if (unitDone && !hit) tick_q <= tick_q + 8'd1;
      end
   end
   // mapped irq held while status set, see RULE10 see RULE11
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irqLines <= 16'h0000;
         irqOut <= 1'b0;
      end else begin
         irqLines <= (ctrl_q[WDTC_STAT_BIT] && irqValid) ?
                     16'(1) << irqMap : 16'h0000;
         irqOut <= |(istat_q & imask_q);
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   force_sets_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (pciRst_n && wrCtrl && hwdata[2]) |=> ctrl_q[0]) // see RULE2
      else $error("force did not set status");
   kb_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (pciRst_n && kbRise && ctrl_q[3]) |=> ctrl_q[0]) // see RULE3
      else $error("keyboard edge missed");
   pci_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !pciRst_n |=> ctrl_q[7:1] == 7'h00 && ctrl_q[0] == $past(ctrl_q[0]))
      else $error("bus reset wrong"); // see RULE5
   rsv_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ctrl_q[7:4] == 4'h0)
      else $error("reserved bits set"); // see RULE6
   irq_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 (irqLines != 16'h0000) |-> $past(ctrl_q[0]) && $past(irqValid))
      else $error("irq without status"); // see RULE10
   irq_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irqOut == $past(|(istat_q & imask_q)))
      else $error("interrupt level wrong"); // see RULE11
   zero_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !enabled |-> !expire) // see RULE7
      else $error("disabled timer expired");
   pulse_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
      kbRise |=> !kbRise) // see RULE4
      else $error("edge pulse too long");
   force_c: cover property (@(posedge mclk) wrCtrl && hwdata[2]);
   kb_c: cover property (@(posedge mclk) kbRise && ctrl_q[3]);
   expire_c: cover property (@(posedge mclk) expire);
endmodule
`default_nettype wire
